// ===== pcrgb_ctrl.v
// top of the pulse-count rgb pwm controller: pin decoder, timeouts, pwm sequencer
// assumes the control pin is synchronous to CLOCK; gate outputs high = switch on
//
// Contract
// - separate 4-bit level register for red, green and blue
// - intensity register selects one of 16 global levels
// - count pin rising edges; latch count after pin high for latch timeout
// - counts 17 to 21 select addresses 1 to 5
// - counts 1 to 16 are data written to current address
// - repeated data bursts go to the same latched address
// - pin low beyond off timeout enters shutdown, outputs off
// - shutdown resets address and all data registers to 1
// - after disable, red is default target from first rising edge
// - color value 1 keeps channel off; higher values longer on-time
// - color on-time is (value minus one) times 128 us
// - off-time is (intensity minus one) times 512 us
// - intensity 1 brightest with no off-time, 16 dimmest
// - mode 1 applies data immediately on latch
// - mode 2 holds colors pending until intensity latches
// - three independent gate drive outputs for red, green, blue
`timescale 1ns/10ps
`default_nettype none
`include "pcrgb_regs.vh"

module pcrgb_ctrl #(
  // latch kept one cycle under the off timeout so a pause never reads as a sleep
  parameter integer LATCH_CYCLES = `PCRGB_LATCH_CYC - 1,
  parameter integer OFF_CYCLES = `PCRGB_OFF_CYC,
  parameter integer ON_STEP_CYCLES = `PCRGB_ON_STEP_CYC,
  parameter integer OFF_STEP_CYCLES = `PCRGB_OFF_STEP_CYC
) (
  // clock and reset
  input wire CLOCK,
  input wire RESET_N,
  // single-wire control pin
  input wire CTRL_PIN,
  // gate drives
  output reg RED_SWITCH_OUT,
  output reg GREEN_SWITCH_OUT,
  output reg BLUE_SWITCH_OUT,
  // status
  output reg ENABLED
);
  localparam [1:0] ST_RED = 2'h0;
  localparam [1:0] ST_GREEN = 2'h1;
  localparam [1:0] ST_BLUE = 2'h2;
  localparam [1:0] ST_DARK = 2'h3;

  // wide enough for the longest phase: 15 x 512 us at 250 MHz
  localparam integer TW = 24;

  reg pin_reg;
  reg active_reg;
  reg [4:0] edge_cnt_reg;
  reg [4:0] addr_reg;
  reg [TW-1:0] high_cnt_reg;
  reg [TW-1:0] low_cnt_reg;
  reg latched_reg;
  reg wr_en_reg;
  reg [3:0] wr_data_reg;
  reg clear_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [TW-1:0] phase_cnt_reg;
  reg [TW-1:0] phase_len;
  reg [3:0] cyc_red_reg;
  reg [3:0] cyc_green_reg;
  reg [3:0] cyc_blue_reg;
  reg [3:0] cyc_inten_reg;

  wire [3:0] red_lvl;
  wire [3:0] green_lvl;
  wire [3:0] blue_lvl;
  wire [3:0] inten_lvl;
  wire [3:0] mode_lvl;

  wire rise = CTRL_PIN && !pin_reg;

  // scales (value - 1) by a step length; value 1 gives zero, stored 0 means 16 edges
  function [TW-1:0] span;
    input [3:0] value;
    input [TW-1:0] step;
    reg [3:0] steps;
    begin
      steps = value - 4'h1;
      span = steps * step;
    end
  endfunction

  // pin edge detect, timeouts and latching
  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      pin_reg <= 1'b0;
      active_reg <= 1'b0;
      edge_cnt_reg <= 5'h00;
      addr_reg <= `PCRGB_ADDR_RED;
      high_cnt_reg <= {TW{1'b0}};
      low_cnt_reg <= {TW{1'b0}};
      latched_reg <= 1'b1;
      wr_en_reg <= 1'b0;
      wr_data_reg <= 4'h0;
      clear_reg <= 1'b0;
    end else begin
      pin_reg <= CTRL_PIN;
      wr_en_reg <= 1'b0;
      clear_reg <= 1'b0;
      if (rise) begin
        // burst counter saturates; counts above 21 are ignored
        if (edge_cnt_reg != 5'h1f) edge_cnt_reg <= edge_cnt_reg + 5'h01;
        latched_reg <= 1'b0;
        active_reg <= 1'b1;
      end
      if (CTRL_PIN) begin
        low_cnt_reg <= {TW{1'b0}};
        if (high_cnt_reg != LATCH_CYCLES[TW-1:0]) begin
          high_cnt_reg <= high_cnt_reg + {{(TW-1){1'b0}}, 1'b1};
        end else if (!latched_reg) begin
          // host pause ends the burst; counts decoded here
          latched_reg <= 1'b1;
          edge_cnt_reg <= 5'h00;
          if (edge_cnt_reg > `PCRGB_DATA_MAX &&
              edge_cnt_reg <= `PCRGB_ADDR_BASE + `PCRGB_ADDR_MODE) begin
            addr_reg <= edge_cnt_reg - `PCRGB_ADDR_BASE;
          end else if (edge_cnt_reg != 5'h00 && edge_cnt_reg <= `PCRGB_DATA_MAX) begin
            // address is kept so further data bursts reuse it
            wr_en_reg <= 1'b1;
            // sixteen edges wrap to 0 in the 4-bit field; span reads it as level 16
            wr_data_reg <= edge_cnt_reg[3:0];
          end
        end
      end else begin
        high_cnt_reg <= {TW{1'b0}};
        if (low_cnt_reg != OFF_CYCLES[TW-1:0]) begin
          low_cnt_reg <= low_cnt_reg + {{(TW-1){1'b0}}, 1'b1};
        end else if (active_reg) begin
          active_reg <= 1'b0;
          clear_reg <= 1'b1;
          addr_reg <= `PCRGB_ADDR_RED;
          edge_cnt_reg <= 5'h00;
          latched_reg <= 1'b1;
        end
      end
    end
  end

  pcrgb_levels u_levels (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .clear(clear_reg),
    .wr_en(wr_en_reg),
    .wr_addr(addr_reg),
    .wr_data(wr_data_reg),
    .red_reg(red_lvl),
    .green_reg(green_lvl),
    .blue_reg(blue_lvl),
    .inten_reg(inten_lvl),
    .mode_reg(mode_lvl)
  );

  // phase length for the current state
  always @* begin
    phase_len = {TW{1'b0}};
    case (state_reg)
      ST_RED: phase_len = span(cyc_red_reg, ON_STEP_CYCLES[TW-1:0]);
      ST_GREEN: phase_len = span(cyc_green_reg, ON_STEP_CYCLES[TW-1:0]);
      ST_BLUE: phase_len = span(cyc_blue_reg, ON_STEP_CYCLES[TW-1:0]);
      ST_DARK: phase_len = span(cyc_inten_reg, OFF_STEP_CYCLES[TW-1:0]);
      default: phase_len = {TW{1'b0}};
    endcase
  end

  always @* begin
    state_next = state_reg;
    if (phase_cnt_reg + {{(TW-1){1'b0}}, 1'b1} >= phase_len) begin
      state_next = state_reg + 2'h1;
    end
  end

  // sequencer: zero-length phases (value 1) pass in one cycle with gate off
  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= ST_DARK;
      phase_cnt_reg <= {TW{1'b0}};
      cyc_red_reg <= `PCRGB_REG_RESET;
      cyc_green_reg <= `PCRGB_REG_RESET;
      cyc_blue_reg <= `PCRGB_REG_RESET;
      cyc_inten_reg <= `PCRGB_REG_RESET;
      RED_SWITCH_OUT <= 1'b0;
      GREEN_SWITCH_OUT <= 1'b0;
      BLUE_SWITCH_OUT <= 1'b0;
      ENABLED <= 1'b0;
    end else begin
      ENABLED <= active_reg;
      if (!active_reg) begin
        state_reg <= ST_DARK;
        phase_cnt_reg <= {TW{1'b0}};
      end else if (state_next != state_reg) begin
        state_reg <= state_next;
        phase_cnt_reg <= {TW{1'b0}};
        if (state_reg == ST_DARK) begin
          // settings sampled only at the cycle boundary
          cyc_red_reg <= red_lvl;
          cyc_green_reg <= green_lvl;
          cyc_blue_reg <= blue_lvl;
          cyc_inten_reg <= inten_lvl;
        end
      end else begin
        phase_cnt_reg <= phase_cnt_reg + {{(TW-1){1'b0}}, 1'b1};
      end
      RED_SWITCH_OUT <= active_reg && state_reg == ST_RED && phase_len != 0;
      GREEN_SWITCH_OUT <= active_reg && state_reg == ST_GREEN && phase_len != 0;
      BLUE_SWITCH_OUT <= active_reg && state_reg == ST_BLUE && phase_len != 0;
    end
  end
endmodule // pcrgb_ctrl

`default_nettype wire

// ===== pcrgb_regs.vh
// register map, field widths and timing constants of the pulse-count rgb pwm controller
// assumes a 250 MHz core clock; included by the design files by bare name
`ifndef PCRGB_REGS_VH
`define PCRGB_REGS_VH

`define PCRGB_ADDR_RED 5'h01
`define PCRGB_ADDR_GREEN 5'h02
`define PCRGB_ADDR_BLUE 5'h03
`define PCRGB_ADDR_INTENSITY 5'h04
`define PCRGB_ADDR_MODE 5'h05
`define PCRGB_ADDR_BASE 5'h10
`define PCRGB_DATA_MAX 5'h10
`define PCRGB_REG_RESET 4'h1
`define PCRGB_MODE_IMMEDIATE 4'h1
`define PCRGB_MODE_SYNC 4'h2
`define PCRGB_CLK_MHZ 250
`define PCRGB_ON_STEP_US 128
`define PCRGB_OFF_STEP_US 512
`define PCRGB_LATCH_US 500
`define PCRGB_OFF_US 500
`define PCRGB_ON_STEP_CYC (`PCRGB_ON_STEP_US * `PCRGB_CLK_MHZ)
`define PCRGB_OFF_STEP_CYC (`PCRGB_OFF_STEP_US * `PCRGB_CLK_MHZ)
`define PCRGB_LATCH_CYC (`PCRGB_LATCH_US * `PCRGB_CLK_MHZ)
`define PCRGB_OFF_CYC (`PCRGB_OFF_US * `PCRGB_CLK_MHZ)

`endif

// ===== pcrgb_levels.v
// register bank: five 4-bit write-only settings plus pending color copies
// assumes writes arrive as one-cycle strobes from the pulse decoder
`timescale 1ns/10ps
`default_nettype none
`include "pcrgb_regs.vh"

module pcrgb_levels (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // write side
  input wire clear,
  input wire wr_en,
  input wire [4:0] wr_addr,
  input wire [3:0] wr_data,
  // applied settings
  output reg [3:0] red_reg,
  output reg [3:0] green_reg,
  output reg [3:0] blue_reg,
  output reg [3:0] inten_reg,
  output reg [3:0] mode_reg
);
  reg [3:0] red_pend_reg;
  reg [3:0] green_pend_reg;
  reg [3:0] blue_pend_reg;
  wire sync_mode = (mode_reg == `PCRGB_MODE_SYNC);
  wire wr_int = wr_en && (wr_addr == `PCRGB_ADDR_INTENSITY);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      red_reg <= `PCRGB_REG_RESET;
      green_reg <= `PCRGB_REG_RESET;
      blue_reg <= `PCRGB_REG_RESET;
      inten_reg <= `PCRGB_REG_RESET;
      mode_reg <= `PCRGB_REG_RESET;
      red_pend_reg <= `PCRGB_REG_RESET;
      green_pend_reg <= `PCRGB_REG_RESET;
      blue_pend_reg <= `PCRGB_REG_RESET;
    end else if (clear) begin
      red_reg <= `PCRGB_REG_RESET;
      green_reg <= `PCRGB_REG_RESET;
      blue_reg <= `PCRGB_REG_RESET;
      inten_reg <= `PCRGB_REG_RESET;
      mode_reg <= `PCRGB_REG_RESET;
      red_pend_reg <= `PCRGB_REG_RESET;
      green_pend_reg <= `PCRGB_REG_RESET;
      blue_pend_reg <= `PCRGB_REG_RESET;
    end else if (wr_en) begin
      case (wr_addr)
        `PCRGB_ADDR_RED: begin
          red_pend_reg <= wr_data;
          if (!sync_mode) red_reg <= wr_data;
        end
        `PCRGB_ADDR_GREEN: begin
          green_pend_reg <= wr_data;
          if (!sync_mode) green_reg <= wr_data;
        end
        `PCRGB_ADDR_BLUE: begin
          blue_pend_reg <= wr_data;
          if (!sync_mode) blue_reg <= wr_data;
        end
        `PCRGB_ADDR_INTENSITY: begin
          inten_reg <= wr_data;
        end
        `PCRGB_ADDR_MODE: begin
          mode_reg <= wr_data;
        end
        default: begin
        end
      endcase
      if (wr_int && sync_mode) begin
        red_reg <= red_pend_reg;
        green_reg <= green_pend_reg;
        blue_reg <= blue_pend_reg;
      end
    end
  end
endmodule // pcrgb_levels

`default_nettype wire

// ===== pcrgb_ctrl_properties.sv
// checker for the pulse-count rgb pwm controller, sees only the top ports
// assumes one clock domain and the small timing parameters of the bench
`timescale 1ns/10ps
`default_nettype none
module pcrgb_ctrl_props #(
  parameter integer LATCH_CYCLES = 20,
  parameter integer OFF_CYCLES = 40,
  parameter integer ON_STEP_CYCLES = 4,
  parameter integer OFF_STEP_CYCLES = 8
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // control pin
  input wire logic CTRL_PIN,
  // gate drives and status
  input wire logic RED_SWITCH_OUT,
  input wire logic GREEN_SWITCH_OUT,
  input wire logic BLUE_SWITCH_OUT,
  input wire logic ENABLED
);
  int low_cnt_reg;
  int red_cnt_reg;
  int grn_cnt_reg;
  // low run saturates so a long sleep cannot wrap the counter
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      low_cnt_reg <= 0;
      red_cnt_reg <= 0;
      grn_cnt_reg <= 0;
    end else begin
      low_cnt_reg <= CTRL_PIN ? 0 : (low_cnt_reg < OFF_CYCLES + 8 ? low_cnt_reg + 1 : low_cnt_reg);
      red_cnt_reg <= RED_SWITCH_OUT ? red_cnt_reg + 1 : 0;
      grn_cnt_reg <= GREEN_SWITCH_OUT ? grn_cnt_reg + 1 : 0;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  sequence s_dark;
    !RED_SWITCH_OUT && !GREEN_SWITCH_OUT && !BLUE_SWITCH_OUT;
  endsequence
  // a pulse cut short by shutdown is not a whole on-time, so it is excluded
  sequence s_red_end;
    $fell(RED_SWITCH_OUT) ##1 ENABLED;
  endsequence
  sequence s_grn_end;
    $fell(GREEN_SWITCH_OUT) ##1 ENABLED;
  endsequence
  AST_RESET_QUIET: assert property ($rose(RESET_N) |-> s_dark ##0 !ENABLED)
    else $error("outputs active right after reset");
  AST_SLEEP_DARK: assert property (!ENABLED && !$past(ENABLED) |-> s_dark)
    else $error("gate drive active in shutdown");
  AST_SLEEP_ENTRY: assert property (low_cnt_reg == OFF_CYCLES + 4 |-> !ENABLED)
    else $error("long low level did not shut down");
  AST_NO_EARLY_SLEEP: assert property ($fell(ENABLED) |-> low_cnt_reg >= OFF_CYCLES)
    else $error("shutdown before off timeout");
  AST_WAKE_ON_EDGE: assert property ($rose(ENABLED) |->
    $past(CTRL_PIN) || $past(CTRL_PIN, 2) || $past(CTRL_PIN, 3))
    else $error("enable without a pin edge");
  AST_ONE_AT_A_TIME: assert property ($onehot0({RED_SWITCH_OUT, GREEN_SWITCH_OUT,
    BLUE_SWITCH_OUT}))
    else $error("two gate drives on together");
  AST_RED_STEPS: assert property (s_red_end |->
    $past(red_cnt_reg) % ON_STEP_CYCLES == 0 && $past(red_cnt_reg) <= 15 * ON_STEP_CYCLES)
    else $error("red on-time not a whole step count");
  AST_GREEN_STEPS: assert property (s_grn_end |->
    $past(grn_cnt_reg) % ON_STEP_CYCLES == 0 && $past(grn_cnt_reg) <= 15 * ON_STEP_CYCLES)
    else $error("green on-time not a whole step count");
  AST_RED_AFTER_GAP: assert property ($rose(RED_SWITCH_OUT) |-> !$past(BLUE_SWITCH_OUT))
    else $error("red started with no off phase after blue");
endmodule // pcrgb_ctrl_props
bind pcrgb_ctrl pcrgb_ctrl_props #(.LATCH_CYCLES(LATCH_CYCLES), .OFF_CYCLES(OFF_CYCLES),
  .ON_STEP_CYCLES(ON_STEP_CYCLES), .OFF_STEP_CYCLES(OFF_STEP_CYCLES)) u_props (
  .CLOCK(CLOCK), .RESET_N(RESET_N), .CTRL_PIN(CTRL_PIN), .RED_SWITCH_OUT(RED_SWITCH_OUT),
  .GREEN_SWITCH_OUT(GREEN_SWITCH_OUT), .BLUE_SWITCH_OUT(BLUE_SWITCH_OUT), .ENABLED(ENABLED));
`default_nettype wire

// ===== pcrgb_host.sv
// host model driving the single-wire control pin with edge bursts
// assumes the bench clock; the pin changes only at falling edges
`timescale 1ns/10ps
`default_nettype none
module pcrgb_host #(
  parameter integer LATCH_CYCLES = 20,
  parameter integer OFF_CYCLES = 40
) (
  // clock
  input wire logic clk,
  // control pin
  output var logic pin
);
  initial pin = 1'h0;
  // n rising edges with low pulses of lo cycles, then a high latch pause
  task automatic burst(input int n, input int lo);
    for (int i = 0; i < n; i++) begin
      @(negedge clk) pin = 1'h0;
      repeat (lo - 1) @(negedge clk);
      @(negedge clk) pin = 1'h1;
    end
    repeat (LATCH_CYCLES + 4) @(negedge clk);
  endtask
  // low past the off timeout puts the device to sleep
  task automatic sleep();
    @(negedge clk) pin = 1'h0;
    repeat (OFF_CYCLES + 6) @(negedge clk);
  endtask
endmodule // pcrgb_host
`default_nettype wire

// ===== pcrgb_ctrl_tb_top.sv
// bench: host model writes settings, pwm run lengths are compared with a model
// assumes the design, its header, the checker and the host model compiled first
`timescale 1ns/10ps
`default_nettype none
module pcrgb_ctrl_tb_top;
  localparam integer ONS = 4;
  localparam integer OFS = 8;
  logic clock = 1'h0;
  logic reset_n = 1'h0;
  logic [31:0] seed = 32'h00000a2d;
  wire logic pin;
  wire logic [2:0] sw;
  wire logic enabled;
  int n_mismatch = 0;
  int cmp_count = 0;
  int lv[1:5];
  int pend[1:5];
  pcrgb_host #(.LATCH_CYCLES(20), .OFF_CYCLES(40)) u_host (.clk(clock), .pin(pin));
  pcrgb_ctrl #(.LATCH_CYCLES(20), .OFF_CYCLES(40), .ON_STEP_CYCLES(ONS),
    .OFF_STEP_CYCLES(OFS)) u_dut (.CLOCK(clock), .RESET_N(reset_n), .CTRL_PIN(pin),
    .RED_SWITCH_OUT(sw[0]), .GREEN_SWITCH_OUT(sw[1]), .BLUE_SWITCH_OUT(sw[2]),
    .ENABLED(enabled));
  initial forever #2 clock = ~clock;
  function automatic int rnd(input int lo, input int hi);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return lo + int'(seed % (hi - lo + 1));
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // data burst to the current address; mode 2 parks colors until intensity
  task automatic dat(input int a, input int d);
    u_host.burst(d, rnd(1, 3));
    if (a == 4 && lv[5] == 2) for (int k = 1; k < 4; k++) lv[k] = pend[k];
    pend[a] = d;
    if (lv[5] != 2 || a > 3) lv[a] = d;
  endtask
  task automatic wr(input int a, input int d);
    u_host.burst(a + 16, rnd(1, 3));
    dat(a, d);
  endtask
  // longest runs over two full periods, after as long again for updates to land
  task automatic settle(input string name);
    int run[0:3];
    int mx[0:3];
    logic [3:0] s;
    repeat (700) @(negedge clock);
    for (int k = 0; k < 4; k++) begin
      run[k] = 0;
      mx[k] = 0;
    end
    repeat (700) begin
      @(negedge clock);
      s = {~|sw, sw};
      for (int k = 0; k < 4; k++) begin
        run[k] = s[k] ? run[k] + 1 : 0;
        if (run[k] > mx[k]) mx[k] = run[k];
      end
    end
    for (int k = 0; k < 3; k++) check(mx[k], (lv[k + 1] - 1) * ONS);
    if (lv[1] > 1 && lv[2] > 1 && lv[3] > 1 && lv[4] > 1)
      check(mx[3], (lv[4] - 1) * OFS);
    check(enabled, 1);
    $display("%s done", name);
  endtask
  initial begin
    repeat (40000) @(posedge clock);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    for (int k = 1; k < 6; k++) begin
      lv[k] = 1;
      pend[k] = 1;
    end
    repeat (16) @(negedge clock);
    reset_n = 1'h1;
    check({enabled, sw}, 0);
    repeat (2) @(negedge clock);
    for (int r = 0; r < 3; r++) begin
      for (int a = 1; a < 5; a++) wr(a, rnd(2, 16));
      dat(4, 16);
      u_host.burst(25, 1);
      settle("immediate");
    end
    wr(1, 1);
    settle("red off");
    wr(5, 2);
    wr(1, rnd(2, 16));
    wr(3, rnd(2, 16));
    settle("pending");
    wr(4, rnd(2, 16));
    settle("synced");
    u_host.sleep();
    check({enabled, sw}, 0);
    for (int k = 1; k < 6; k++) begin
      lv[k] = 1;
      pend[k] = 1;
    end
    dat(1, rnd(2, 16));
    settle("after sleep");
    end_of_test();
  end
endmodule // pcrgb_ctrl_tb_top
`default_nettype wire
